// *** rtca_pkg.sv ***
// rtca_pkg: constants and carrier types for the clock and calendar core
package rtca_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned     CLK_PERIOD_NS = 100;
  localparam longint unsigned SECOND_NS     = 64'd1000000000;
  localparam int unsigned     TICK_CYCLES   = int'(SECOND_NS / CLK_PERIOD_NS);

  ////////////////////////////////////////////////////////////////////////////////
  // register bus
  localparam int unsigned APB_AW = 8;
  localparam int unsigned NREG   = 16;

  // register indices, byte address is four times the index
  localparam logic [3:0] IDX_SEC      = 4'h0;
  localparam logic [3:0] IDX_MIN      = 4'h1;
  localparam logic [3:0] IDX_HOUR     = 4'h2;
  localparam logic [3:0] IDX_WEEK     = 4'h3;
  localparam logic [3:0] IDX_DATE     = 4'h4;
  localparam logic [3:0] IDX_MONTH    = 4'h5;
  localparam logic [3:0] IDX_YEAR     = 4'h6;
  localparam logic [3:0] IDX_RAM      = 4'h7;
  localparam logic [3:0] IDX_ALM_MIN  = 4'h8;
  localparam logic [3:0] IDX_ALM_HOUR = 4'h9;
  localparam logic [3:0] IDX_ALM_WD   = 4'ha;
  localparam logic [3:0] IDX_ALM_CTRL = 4'he;

  ////////////////////////////////////////////////////////////////////////////////
  // writable bits
  localparam logic [7:0] MASK_SEC   = 8'h7f;
  localparam logic [7:0] MASK_MIN   = 8'h7f;
  localparam logic [7:0] MASK_HOUR  = 8'h3f;
  localparam logic [7:0] MASK_WEEK  = 8'h7f;
  localparam logic [7:0] MASK_DATE  = 8'h3f;
  localparam logic [7:0] MASK_MONTH = 8'h1f;

  // field positions
  localparam int unsigned ALM_MASK_BIT  = 7;
  localparam int unsigned CTRL_FLAG_BIT = 0;
  localparam int unsigned CTRL_TSEL_BIT = 1;
  localparam int unsigned CTRL_IEN_BIT  = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // bcd values and reset values
  localparam logic [7:0] BCD_00 = 8'h00;
  localparam logic [7:0] BCD_01 = 8'h01;
  localparam logic [7:0] BCD_02 = 8'h02;
  localparam logic [7:0] BCD_04 = 8'h04;
  localparam logic [7:0] BCD_06 = 8'h06;
  localparam logic [7:0] BCD_09 = 8'h09;
  localparam logic [7:0] BCD_11 = 8'h11;
  localparam logic [7:0] BCD_12 = 8'h12;
  localparam logic [7:0] BCD_23 = 8'h23;
  localparam logic [7:0] BCD_28 = 8'h28;
  localparam logic [7:0] BCD_29 = 8'h29;
  localparam logic [7:0] BCD_30 = 8'h30;
  localparam logic [7:0] BCD_31 = 8'h31;
  localparam logic [7:0] BCD_59 = 8'h59;
  localparam logic [7:0] BCD_99 = 8'h99;
  localparam logic [7:0] WEEK_FIRST = 8'h01;
  localparam logic [7:0] WEEK_LAST  = 8'h40;
  localparam logic [7:0] RST_TIME   = 8'h00;
  localparam logic [7:0] RST_CAL    = 8'h01;
  localparam logic [7:0] RST_ALM    = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // apb carriers
  typedef struct packed {
    logic [APB_AW-1:0] paddr;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [31:0]       pwdata;
  } rtca_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } rtca_apb_rsp_s;

endpackage : rtca_pkg

// *** rtca_core.sv ***
// rtca_core: bcd time, calendar, scratch byte and alarm compare behind apb
//
// How it works
// - scratch byte at index 7 stores any value
// - unused time bits ignore writes, read zero
// - seconds, minutes, hours kept as bcd
// - seconds count 00..59, wrap carries minutes
// - minutes count 00..59, wrap carries hours
// - hours 00..23, wrap advances weekday and date
// - weekday one-hot rotates 01h up to 40h
// - 01h is sunday through 40h saturday
// - calendar runs 2000 through 2099 automatically
// - date wraps at 31 or 30 by month
// - february wraps at 28, or 29 leap
// - year multiple of four is leap, 00 too
// - month 01..12, wrap advances year
// - year bcd 00..99 then back to 00
// - date, month, year stored as bcd
// - alarm compare registers 8, 9, a with mask bit
// - alarm match sets flag, drives irq low when enable bit 2 is set
// - target select picks date or weekday compare
// - alarm flag stays set until host clears
module rtca_core #(
  parameter int unsigned TICK_CYCLES_P = rtca_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    reset_n,
  // register bus
  input  wire rtca_pkg::rtca_apb_req_s apb_req,
  output rtca_pkg::rtca_apb_rsp_s      apb_rsp,
  // alarm interrupt
  output logic                         alarm_irq_n
);
  import rtca_pkg::*;

  localparam int unsigned TW = $clog2(TICK_CYCLES_P);

  ////////////////////////////////////////////////////////////////////////////////
  // elaboration check
  generate
    if (TICK_CYCLES_P < 16) begin : g_bad_tick
      $error("tick period too short");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // bcd helpers
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [3:0] tens;
    tens = v[7:4] + 4'h1;
    if (v[3:0] == 4'h9) begin
      bcd_inc = {tens, 4'h0};
    end else begin
      bcd_inc = v + 8'h01;
    end
  endfunction : bcd_inc

  function automatic logic [7:0] bcd_step(input logic [7:0] v,
                                          input logic [7:0] last,
                                          input logic [7:0] first);
    bcd_step = (v == last) ? first : bcd_inc(v);
  endfunction : bcd_step

  ////////////////////////////////////////////////////////////////////////////////
  // state
  logic [TW-1:0] presc_q;
  logic [7:0]    sec_q;
  logic [7:0]    min_q;
  logic [7:0]    hour_q;
  logic [7:0]    week_q;
  logic [7:0]    date_q;
  logic [7:0]    mon_q;
  logic [7:0]    year_q;
  logic [7:0]    ram_q;
  logic [7:0]    alm_min_q;
  logic [7:0]    alm_hour_q;
  logic [7:0]    alm_wd_q;
  logic          tsel_q;
  logic          ien_q;
  logic          flag_q;
  logic          alm_upd_q;
  logic          irq_n_q;
  logic [7:0]    rdata_q;
  logic          err_q;

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire logic [3:0]      widx  = apb_req.paddr[5:2];
  wire logic [7:0]      wbyte = apb_req.pwdata[7:0];
  wire logic            idx_ok = (widx <= IDX_ALM_WD) || (widx == IDX_ALM_CTRL);
  wire logic            hit_ok = (apb_req.paddr[APB_AW-1:6] == '0)
                                 && (apb_req.paddr[1:0] == 2'b00) && idx_ok;
  wire logic            setup  = apb_req.psel && !apb_req.penable;
  wire logic            access = apb_req.psel && apb_req.penable;
  wire logic            wr_en  = access && apb_req.pwrite && hit_ok;
  logic [NREG-1:0]      wr_vec;
  logic [7:0]           view [NREG];

  generate
    for (genvar i = 0; i < NREG; i++) begin : g_dec
      assign wr_vec[i] = wr_en && (widx == 4'(i));
      if (i > 10 && i != 14) begin : g_hole
        assign view[i] = 8'h00;
      end
    end
  endgenerate

  assign view[IDX_SEC]      = sec_q;
  assign view[IDX_MIN]      = min_q;
  assign view[IDX_HOUR]     = hour_q;
  assign view[IDX_WEEK]     = week_q;
  assign view[IDX_DATE]     = date_q;
  assign view[IDX_MONTH]    = mon_q;
  assign view[IDX_YEAR]     = year_q;
  assign view[IDX_RAM]      = ram_q;
  assign view[IDX_ALM_MIN]  = alm_min_q;
  assign view[IDX_ALM_HOUR] = alm_hour_q;
  assign view[IDX_ALM_WD]   = alm_wd_q;
  assign view[IDX_ALM_CTRL] = {5'h00, ien_q, tsel_q, flag_q};

  assign apb_rsp = {{24'h000000, rdata_q},   // prdata
                    1'b1,                    // pready
                    access && err_q};        // pslverr

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
      err_q   <= 1'b0;
    end else if (setup) begin
      rdata_q <= hit_ok ? view[widx] : 8'h00;
      err_q   <= !hit_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one second tick
  wire logic tick = (presc_q == TW'(TICK_CYCLES_P - 1));
  wire logic [TW-1:0] presc_d = (tick || wr_vec[IDX_SEC]) ? '0 : presc_q + TW'(1);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // carries
  wire logic [1:0] yr_mod4 = year_q[1:0] + {year_q[4], 1'b0};
  wire logic       leap    = (yr_mod4 == 2'b00);
  wire logic       short_m = (mon_q == BCD_04) || (mon_q == BCD_06)
                             || (mon_q == BCD_09) || (mon_q == BCD_11);
  wire logic [7:0] feb_last  = leap ? BCD_29 : BCD_28;
  wire logic [7:0] date_last = short_m ? BCD_30 :
                               (mon_q == BCD_02) ? feb_last : BCD_31;

  wire logic sec_wrap  = tick && (sec_q == BCD_59);
  wire logic min_wrap  = sec_wrap && (min_q == BCD_59);
  wire logic day_inc   = min_wrap && (hour_q == BCD_23);
  wire logic date_wrap = day_inc && (date_q == date_last);
  wire logic mon_wrap  = date_wrap && (mon_q == BCD_12);

  wire logic [7:0] week_rot = (week_q == WEEK_LAST) ? WEEK_FIRST
                                                     : {week_q[6:0], 1'b0};

  ////////////////////////////////////////////////////////////////////////////////
  // next time and calendar values
  wire logic [7:0] sec_d  = wr_vec[IDX_SEC]  ? (wbyte & MASK_SEC) :
                            tick ? bcd_step(sec_q, BCD_59, BCD_00) : sec_q;
  wire logic [7:0] min_d  = wr_vec[IDX_MIN]  ? (wbyte & MASK_MIN) :
                            sec_wrap ? bcd_step(min_q, BCD_59, BCD_00) : min_q;
  wire logic [7:0] hour_d = wr_vec[IDX_HOUR] ? (wbyte & MASK_HOUR) :
                            min_wrap ? bcd_step(hour_q, BCD_23, BCD_00) : hour_q;
  wire logic [7:0] week_d = wr_vec[IDX_WEEK] ? (wbyte & MASK_WEEK) :
                            day_inc ? week_rot : week_q;
  wire logic [7:0] date_d = wr_vec[IDX_DATE] ? (wbyte & MASK_DATE) :
                            day_inc ? bcd_step(date_q, date_last, BCD_01) : date_q;
  wire logic [7:0] mon_d  = wr_vec[IDX_MONTH] ? (wbyte & MASK_MONTH) :
                            date_wrap ? bcd_step(mon_q, BCD_12, BCD_01) : mon_q;
  wire logic [7:0] year_d = wr_vec[IDX_YEAR] ? wbyte :
                            mon_wrap ? bcd_step(year_q, BCD_99, BCD_00) : year_q;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sec_q  <= RST_TIME;
      min_q  <= RST_TIME;
      hour_q <= RST_TIME;
      week_q <= WEEK_FIRST;
      date_q <= RST_CAL;
      mon_q  <= RST_CAL;
      year_q <= RST_CAL;
    end else begin
      sec_q  <= sec_d;
      min_q  <= min_d;
      hour_q <= hour_d;
      week_q <= week_d;
      date_q <= date_d;
      mon_q  <= mon_d;
      year_q <= year_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // scratch byte and alarm compare registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ram_q      <= 8'h00;
      alm_min_q  <= RST_ALM;
      alm_hour_q <= RST_ALM;
      alm_wd_q   <= RST_ALM;
    end else begin
      if (wr_vec[IDX_RAM]) begin
        ram_q <= wbyte;
      end
      if (wr_vec[IDX_ALM_MIN]) begin
        alm_min_q <= wbyte;
      end
      if (wr_vec[IDX_ALM_HOUR]) begin
        alm_hour_q <= wbyte;
      end
      if (wr_vec[IDX_ALM_WD]) begin
        alm_wd_q <= wbyte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // alarm compare
  wire logic min_ok  = alm_min_q[ALM_MASK_BIT]
                       || (alm_min_q[6:0] == min_q[6:0]);
  wire logic hour_ok = alm_hour_q[ALM_MASK_BIT]
                       || (alm_hour_q[5:0] == hour_q[5:0]);
  wire logic date_eq = (alm_wd_q[5:0] == date_q[5:0]);
  wire logic week_eq = |(alm_wd_q[6:0] & week_q[6:0]);
  wire logic wd_ok   = alm_wd_q[ALM_MASK_BIT]
                       || (tsel_q ? date_eq : week_eq);
  wire logic alm_hit = alm_upd_q && min_ok && hour_ok && wd_ok;

  wire logic ctrl_wr  = wr_vec[IDX_ALM_CTRL];
  wire logic flag_clr = ctrl_wr && !wbyte[CTRL_FLAG_BIT];
  wire logic flag_d   = alm_hit || (flag_q && !flag_clr);
  wire logic tsel_d   = ctrl_wr ? wbyte[CTRL_TSEL_BIT] : tsel_q;
  wire logic ien_d    = ctrl_wr ? wbyte[CTRL_IEN_BIT] : ien_q;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      alm_upd_q <= 1'b0;
      flag_q    <= 1'b0;
      tsel_q    <= 1'b0;
      ien_q     <= 1'b0;
      irq_n_q   <= 1'b1;
    end else begin
      alm_upd_q <= sec_wrap;
      flag_q    <= flag_d;
      tsel_q    <= tsel_d;
      ien_q     <= ien_d;
      irq_n_q   <= !(flag_d && ien_d);
    end
  end

  assign alarm_irq_n = irq_n_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_sec_end;
    tick && (sec_q == BCD_59) && !wr_vec[IDX_SEC];
  endsequence

  sequence s_min_end;
    s_sec_end ##0 ((min_q == BCD_59) && !wr_vec[IDX_MIN]);
  endsequence

  sequence s_day_end;
    day_inc && !wr_vec[IDX_DATE] && !wr_vec[IDX_MONTH];
  endsequence

  a_ram_readback: assert property (
    setup && hit_ok && (widx == IDX_RAM) |=> apb_rsp.prdata[7:0] == $past(ram_q))
    else $error("scratch byte readback wrong");

  a_unused_zero: assert property (
    !(sec_q[7] || min_q[7] || (hour_q[7:6] != 2'b00) || week_q[7]
      || (date_q[7:6] != 2'b00) || (mon_q[7:5] != 3'b000)))
    else $error("unused time bit set");

  a_sec_wrap: assert property (
    s_sec_end |=> (sec_q == BCD_00) && (min_q != $past(min_q) || $past(wr_vec[IDX_MIN])))
    else $error("seconds wrap or carry wrong");

  a_min_wrap: assert property (
    s_min_end ##0 !wr_vec[IDX_HOUR] |=> (min_q == BCD_00) && (hour_q != $past(hour_q)))
    else $error("minutes wrap or carry wrong");

  a_hour_wrap: assert property (
    day_inc && !wr_vec[IDX_HOUR] |=> hour_q == BCD_00)
    else $error("hours did not wrap");

  a_week_rotate: assert property (
    day_inc && !wr_vec[IDX_WEEK] && (week_q == WEEK_LAST) |=> week_q == WEEK_FIRST)
    else $error("weekday did not return to first");

  a_feb_normal: assert property (
    s_day_end ##0 ((mon_q == BCD_02) && (date_q == BCD_28) && !leap)
    |=> (date_q == BCD_01) && (mon_q == $past(mon_q) + 8'h01))
    else $error("february normal year wrap wrong");

  a_feb_leap: assert property (
    s_day_end ##0 ((mon_q == BCD_02) && (date_q == BCD_28) && (year_q == BCD_00))
    |=> date_q == BCD_29)
    else $error("year 00 not leap");

  a_short_month: assert property (
    s_day_end ##0 (short_m && (date_q == BCD_30)) |=> date_q == BCD_01)
    else $error("thirty day month wrap wrong");

  a_year_wrap: assert property (
    mon_wrap && !wr_vec[IDX_MONTH] && !wr_vec[IDX_YEAR] && (year_q == BCD_99)
    |=> (mon_q == BCD_01) && (year_q == BCD_00))
    else $error("month or year wrap wrong");

  a_alarm_raise: assert property (
    alm_hit && ien_q && !ctrl_wr |=> flag_q && !alarm_irq_n)
    else $error("alarm did not raise flag and irq");

  a_flag_sticky: assert property (
    flag_q && !flag_clr |=> flag_q [*1] ##0 (view[IDX_ALM_CTRL][CTRL_FLAG_BIT]))
    else $error("alarm flag dropped");

  a_once_minute: assert property (
    alm_hit |-> $past(sec_wrap) ##1 !alm_upd_q [*8])
    else $error("alarm evaluated off the minute");

  a_scratch_write: assert property (
    wr_vec[IDX_RAM] |=> ram_q == $past(wbyte))
    else $error("scratch byte write lost");

  a_sec_step: assert property (
    tick && !wr_vec[IDX_SEC] && (sec_q[3:0] != 4'h9) |=> sec_q == $past(sec_q) + 8'h01)
    else $error("seconds units step wrong");

  a_week_shift: assert property (
    day_inc && !wr_vec[IDX_WEEK] && (week_q != WEEK_LAST)
    |=> week_q == ($past(week_q) << 1))
    else $error("weekday did not rotate");

  a_long_month: assert property (
    s_day_end ##0 (!short_m && (mon_q != BCD_02) && (date_q == BCD_31))
    |=> (date_q == BCD_01) && (mon_q != $past(mon_q)))
    else $error("long month wrap wrong");

  a_feb_leap_end: assert property (
    s_day_end ##0 ((mon_q == BCD_02) && (date_q == BCD_29))
    |=> (date_q == BCD_01) && (mon_q == $past(mon_q) + 8'h01))
    else $error("february leap year wrap wrong");

  a_flag_clear: assert property (
    flag_clr && !alm_hit |=> !flag_q)
    else $error("alarm flag not cleared");

  a_flag_quiet: assert property (
    !alm_upd_q && !flag_q |=> !flag_q)
    else $error("alarm flag set off the minute");

  a_date_miss: assert property (
    alm_upd_q && tsel_q && !alm_wd_q[ALM_MASK_BIT] && (alm_wd_q[5:0] != date_q[5:0])
    && !flag_q && !ctrl_wr |=> !flag_q)
    else $error("date target matched wrongly");

endmodule : rtca_core

// *** rtca_host.sv ***
// rtca_host: apb master model standing in for the host controller
module rtca_host (
  // clock
  input  wire logic                    ref_clk,
  // register bus
  output rtca_pkg::rtca_apb_req_s      apb_req,
  input  wire rtca_pkg::rtca_apb_rsp_s apb_rsp
);
  timeunit 1ns;
  timeprecision 1ns;
  import rtca_pkg::*;

  logic hung;

  initial begin
    hung    = 1'b0;
    apb_req = '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one transfer: setup, then access until pready
  task automatic xfer(input logic wr, input logic [3:0] idx, input logic [7:0] wdat,
                      output logic [7:0] rdat, output logic err);
    int n;
    @(posedge ref_clk);
    apb_req.paddr   <= {2'b00, idx, 2'b00};
    apb_req.pwrite  <= wr;
    apb_req.pwdata  <= {24'h000000, wdat};
    apb_req.psel    <= 1'b1;
    apb_req.penable <= 1'b0;
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 64);
    if (apb_rsp.pready !== 1'b1) hung = 1'b1;
    rdat = apb_rsp.prdata[7:0];
    err  = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
    apb_req.pwdata  <= ~apb_req.pwdata;
  endtask : xfer

endmodule : rtca_host

// *** tb_top.sv ***
// tb_top: self-checking bench for the clock and calendar core
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rtca_pkg::*;

  localparam int unsigned TICK = 20;
  localparam logic [7:0] RST_EXP [11] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01,
                                          8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] MASKS [6] = '{MASK_SEC, MASK_MIN, MASK_HOUR, MASK_WEEK,
                                       MASK_DATE, MASK_MONTH};
  localparam logic [39:0] ROLLS [8] = '{40'h2301310123, 40'h2304300223, 40'h2302280423,
    40'h2402280823, 40'h2402291023, 40'h0002282023, 40'h9912314023, 40'h2306154009};
  localparam logic [31:0] ALMS [8] = '{32'h04081008, 32'h0408800a, 32'h06081015,
    32'h06091015, 32'h04081180, 32'h00881008, 32'h04081010, 32'h06081016};

  logic          ref_clk;
  logic          reset_n;
  logic          alarm_irq_n;
  rtca_apb_req_s apb_req;
  rtca_apb_rsp_s apb_rsp;
  int            n_fail;
  int            total_checks;
  logic [7:0]    q;
  logic          e;

  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;

  rtca_core #(.TICK_CYCLES_P(TICK)) i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .alarm_irq_n(alarm_irq_n));
  rtca_host i_host (.ref_clk(ref_clk), .apb_req(apb_req), .apb_rsp(apb_rsp));

  ////////////////////////////////////////////////////////////////////////////////
  // compares and closing
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk1

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (60000) @(posedge ref_clk);
    n_fail++;
    wrap_up();
  end

  always @(posedge ref_clk) begin
    if (i_host.hung === 1'b1) begin
      n_fail++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus shorthands
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    logic [7:0] x;
    i_host.xfer(1'b1, idx, d, x, e);
  endtask : wr

  task automatic rd(input logic [3:0] idx, output logic [7:0] d);
    i_host.xfer(1'b0, idx, 8'h00, d, e);
  endtask : rd

  task automatic set_time(input logic [7:0] yr, mo, dt, wk, hr, mi, sc);
    wr(IDX_YEAR, yr);
    wr(IDX_MONTH, mo);
    wr(IDX_DATE, dt);
    wr(IDX_WEEK, wk);
    wr(IDX_HOUR, hr);
    wr(IDX_MIN, mi);
    wr(IDX_SEC, sc);
  endtask : set_time

  ////////////////////////////////////////////////////////////////////////////////
  // expectation functions
  function automatic int b2i(input logic [7:0] b);
    return b[7:4] * 10 + b[3:0];
  endfunction : b2i

  function automatic logic [7:0] i2b(input int n);
    return {4'(n / 10), 4'(n % 10)};
  endfunction : i2b

  function automatic int last_day(input int m, input int y);
    if (m == 4 || m == 6 || m == 9 || m == 11) return 30;
    if (m == 2) return (y % 4 == 0) ? 29 : 28;
    return 31;
  endfunction : last_day

  function automatic logic [23:0] next_day(input logic [7:0] dt, mo, yr);
    int d;
    int m;
    int y;
    d = b2i(dt);
    m = b2i(mo);
    y = b2i(yr);
    if (d < last_day(m, y)) d++;
    else begin
      d = 1;
      m = (m == 12) ? 1 : m + 1;
      y = (m == 1) ? (y + 1) % 100 : y;
    end
    return {i2b(d), i2b(m), i2b(y)};
  endfunction : next_day

  function automatic logic alarm_hit(input logic [7:0] c, am, ah, aw, mi, hr, wk, dt);
    logic wd_ok;
    wd_ok = aw[7] | (c[1] ? (aw[5:0] == dt[5:0]) : |(aw[6:0] & wk[6:0]));
    return (am[7] | (am[6:0] == mi[6:0])) & (ah[7] | (ah[5:0] == hr[5:0])) & wd_ok;
  endfunction : alarm_hit

  ////////////////////////////////////////////////////////////////////////////////
  // rollover at 59 seconds, fields {yr, mo, dt, wk, hr}
  task automatic roll(input logic [39:0] c);
    logic [23:0] nx;
    logic [7:0]  w;
    logic        nd;
    nd = (c[7:0] == BCD_23);
    nx = nd ? next_day(c[23:16], c[31:24], c[39:32]) : {c[23:16], c[31:24], c[39:32]};
    w  = !nd ? c[15:8] : (c[15:8] == WEEK_LAST) ? WEEK_FIRST : {c[14:8], 1'b0};
    set_time(c[39:32], c[31:24], c[23:16], c[15:8], c[7:0], BCD_59, BCD_59);
    repeat (TICK) @(posedge ref_clk);
    rd(IDX_SEC, q);
    chk8(q, BCD_00, "sec wrap");
    rd(IDX_MIN, q);
    chk8(q, BCD_00, "min wrap");
    rd(IDX_HOUR, q);
    chk8(q, nd ? BCD_00 : i2b(b2i(c[7:0]) + 1), "hour");
    rd(IDX_WEEK, q);
    chk8(q, w, "weekday");
    rd(IDX_DATE, q);
    chk8(q, nx[23:16], "date");
    rd(IDX_MONTH, q);
    chk8(q, nx[15:8], "month");
    rd(IDX_YEAR, q);
    chk8(q, nx[7:0], "year");
  endtask : roll

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [7:0] v;
    logic [31:0] a;
    logic        hit;
    int          m;
    int          y;
    n_fail = 0;
    total_checks = 0;
    reset_n = 1'b0;
    void'($urandom(32'h4b0361fa));
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      rd(4'(i), q);
      chk8(q, RST_EXP[i], "reset value");
    end
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      wr(IDX_RAM, v);
      wr(4'hb, ~v);
      rd(IDX_RAM, q);
      chk8(q, v, "scratch");
    end
    rd(4'hb, q);
    chk1(e, 1'b1, "unmapped error");
    chk8(q, 8'h00, "unmapped data");
    $display("test scratch done");
    wr(IDX_SEC, BCD_00);
    for (int i = 5; i >= 0; i--) begin
      wr(4'(i), 8'hff);
      rd(4'(i), q);
      chk8(q, MASKS[i], "unused bits");
      wr(4'(i), RST_EXP[i]);
    end
    $display("test unused bits done");
    foreach (ROLLS[i]) roll(ROLLS[i]);
    for (int i = 0; i < 4; i++) begin
      m = 1 + $urandom % 12;
      y = $urandom % 100;
      roll({i2b(y), i2b(m), i2b(last_day(m, y)), 8'(1 << ($urandom % 7)), BCD_23});
    end
    $display("test rollover done");
    foreach (ALMS[i]) begin
      a = ALMS[i];
      wr(IDX_ALM_CTRL, a[31:24]);
      wr(IDX_ALM_MIN, a[23:16]);
      wr(IDX_ALM_HOUR, a[15:8]);
      wr(IDX_ALM_WD, a[7:0]);
      set_time(8'h23, 8'h05, 8'h15, 8'h08, 8'h10, 8'h07, BCD_59);
      hit = alarm_hit(a[31:24], a[23:16], a[15:8], a[7:0], 8'h08, 8'h10, 8'h08, 8'h15);
      repeat (TICK + 3) @(posedge ref_clk);
      chk1(alarm_irq_n, ~(hit & a[26]), "irq on match");
      repeat (5) @(posedge ref_clk);
      rd(IDX_ALM_CTRL, q);
      chk8(q, {5'h00, a[26:25], hit}, "flag held");
      wr(IDX_ALM_CTRL, {a[31:25], 1'b1});
      rd(IDX_ALM_CTRL, q);
      chk8(q, {5'h00, a[26:25], hit}, "flag after one");
      wr(IDX_ALM_CTRL, {a[31:25], 1'b0});
      repeat (TICK) @(posedge ref_clk);
      chk1(alarm_irq_n, 1'b1, "irq cleared");
      rd(IDX_ALM_CTRL, q);
      chk8(q, {5'h00, a[26:25], 1'b0}, "one event a minute");
    end
    $display("test alarm done");
    wrap_up();
  end

endmodule : tb_top
